// >>> rtl/aof_pkg.sv
// package: constants and types of the adc output formatter
package aof_pkg;
	localparam int DATA_W = 14;
	localparam int RAW_W = 16;
	localparam int CORR_W = 17;
	localparam int LFSR_W = 15;
	localparam int STAT_W = 2;
	localparam int CTRL_W = 6;

	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_MASK = 8'h08;
	localparam logic [7:0] REG_LAST = 8'h0C;

	// control field positions
	localparam int CTRL_FMT_LO = 0;
	localparam int CTRL_OM_LO = 2;
	localparam int CTRL_SCR_BIT = 4;
	localparam int CTRL_DITH_BIT = 5;

	// status and mask bit positions
	localparam int STAT_OVR_BIT = 0;
	localparam int STAT_SMP_BIT = 1;

	// reset values
	localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
	localparam logic [STAT_W-1:0] MASK_RST = 2'h0;
	localparam logic [LFSR_W-1:0] LFSR_SEED = 15'h0001;

	// code range of a 14-bit two's complement result
	localparam logic signed [CORR_W-1:0] CODE_MAX = 17'sh01FFF;
	localparam logic signed [CORR_W-1:0] CODE_MIN = 17'sh1E000;
	localparam logic [DATA_W-1:0] CLAMP_HI = 14'h1FFF;
	localparam logic [DATA_W-1:0] CLAMP_LO = 14'h2000;
	localparam logic [DATA_W-1:0] MSB_FLIP = 14'h2000;

	// output mode, coded as the four-level mode select
	typedef enum logic [1:0] {
		OM_FULL = 2'h0,
		OM_DEMUX = 2'h1,
		OM_LVDS_LP = 2'h2,
		OM_LVDS = 2'h3
	} aof_omode_type;
endpackage

// >>> rtl/aof_top.sv
// module: adc output formatter with apb control and sample buses
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module aof_top (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// converter core
	input wire logic encode_clock_in,
	input wire logic signed [15:0] conv_result,
	output logic [13:0] dither_dac,
	output logic duty_stab_en,
	output logic lvds_enable,
	output logic lvds_low_power,
	// sample outputs
	output logic [13:0] bus_a_data,
	output logic [13:0] bus_b_data,
	output logic bus_a_range_flag,
	output logic bus_b_range_flag,
	output logic over_range_flag_p,
	output logic over_range_flag_n,
	output logic forwarded_clock_a,
	output logic forwarded_clock_b,
	// interrupt
	output logic irq
);

	function automatic logic f_mapped(input logic [7:0] a);
		f_mapped = (a == aof_pkg::REG_CTRL) || (a == aof_pkg::REG_STAT) ||
			(a == aof_pkg::REG_MASK) || (a == aof_pkg::REG_LAST);
	endfunction

	function automatic logic [13:0] f_scr(input logic [13:0] d, input logic en);
		f_scr = en ? {d[13:1] ^ {13{d[0]}}, d[0]} : d;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// encode clock sampling
	logic [2:0] enc_sync_ff;
	logic [2:0] nxt_enc_sync;
	logic enc_lvl_ff;
	logic nxt_enc_lvl;
	logic enc_rise;
	logic enc_fall;

	// a level counts only once the second and third stages agree
	always_comb begin
		nxt_enc_sync = {enc_sync_ff[1:0], encode_clock_in};
		nxt_enc_lvl = enc_lvl_ff;
		if (enc_sync_ff[1] == enc_sync_ff[2]) begin
			nxt_enc_lvl = enc_sync_ff[2];
		end
		enc_rise = nxt_enc_lvl & ~enc_lvl_ff;
		enc_fall = ~nxt_enc_lvl & enc_lvl_ff;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enc_sync_ff <= 3'h0;
			enc_lvl_ff <= 1'b0;
		end else begin
			enc_sync_ff <= nxt_enc_sync;
			enc_lvl_ff <= nxt_enc_lvl;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// apb registers
	logic [5:0] ctrl_ff;
	logic [5:0] nxt_ctrl;
	logic [1:0] mask_ff;
	logic [1:0] nxt_mask;
	logic [1:0] stat_ff;
	logic [1:0] nxt_stat;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;
	logic pslverr_ff;
	logic nxt_pslverr;
	logic pready_ff;
	logic irq_ff;
	logic nxt_irq;
	logic [1:0] stat_set;
	logic [13:0] pend_data_ff;
	logic pend_flag_ff;
	logic apb_acc;

	always_comb begin
		apb_acc = psel & penable & pready_ff;
		nxt_ctrl = ctrl_ff;
		nxt_mask = mask_ff;
		nxt_prdata = prdata_ff;
		nxt_pslverr = pslverr_ff;
		// read data is staged in the setup cycle so the slave needs no wait
		if (psel && !penable) begin
			nxt_pslverr = !f_mapped(paddr);
			unique case (paddr)
				aof_pkg::REG_CTRL: nxt_prdata = {26'h0, ctrl_ff};
				aof_pkg::REG_STAT: nxt_prdata = {30'h0, stat_ff};
				aof_pkg::REG_MASK: nxt_prdata = {30'h0, mask_ff};
				aof_pkg::REG_LAST: nxt_prdata = {17'h0, pend_flag_ff, pend_data_ff};
				default: nxt_prdata = 32'h0;
			endcase
		end
		if (apb_acc && pwrite && paddr == aof_pkg::REG_CTRL) begin
			nxt_ctrl = pwdata[5:0];
		end
		if (apb_acc && pwrite && paddr == aof_pkg::REG_MASK) begin
			nxt_mask = pwdata[1:0];
		end
		// only bits that were read get cleared, and a new event wins
		nxt_stat = stat_ff;
		if (apb_acc && !pwrite && paddr == aof_pkg::REG_STAT) begin
			nxt_stat = stat_ff & ~prdata_ff[1:0];
		end
		nxt_stat = nxt_stat | stat_set;
		nxt_irq = |(stat_ff & mask_ff);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= aof_pkg::CTRL_RST;
			mask_ff <= aof_pkg::MASK_RST;
			stat_ff <= 2'h0;
			prdata_ff <= 32'h0;
			pslverr_ff <= 1'b0;
			pready_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			mask_ff <= nxt_mask;
			stat_ff <= nxt_stat;
			prdata_ff <= nxt_prdata;
			pslverr_ff <= nxt_pslverr;
			pready_ff <= 1'b1;
			irq_ff <= nxt_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sample path and output stage
	aof_pkg::aof_omode_type om;
	logic twos;
	logic scr_en;
	logic dith_en;
	logic demux;
	logic lvds;
	logic signed [16:0] corr;
	logic ovr;
	logic [13:0] clamped;
	logic [13:0] fmtd;
	logic out_upd;
	logic [14:0] lfsr_ff;
	logic [14:0] nxt_lfsr;
	logic [13:0] dither_ff;
	logic [13:0] nxt_dither;
	logic [13:0] nxt_pend_data;
	logic nxt_pend_flag;
	logic [13:0] holdb_data_ff;
	logic [13:0] nxt_holdb_data;
	logic holdb_flag_ff;
	logic nxt_holdb_flag;
	logic phase_ff;
	logic nxt_phase;
	logic [13:0] bus_a_ff;
	logic [13:0] nxt_bus_a;
	logic [13:0] bus_b_ff;
	logic [13:0] nxt_bus_b;
	logic flag_a_ff;
	logic nxt_flag_a;
	logic flag_b_ff;
	logic nxt_flag_b;
	logic ovr_p_ff;
	logic nxt_ovr_p;
	logic clk_a_ff;
	logic nxt_clk_a;
	logic clk_b_ff;
	logic ovr_n_ff;
	logic dcs_ff;
	logic lvds_en_ff;
	logic lvds_lp_ff;

	always_comb begin
		om = aof_pkg::aof_omode_type'(ctrl_ff[aof_pkg::CTRL_OM_LO +: 2]);
		twos = ctrl_ff[aof_pkg::CTRL_FMT_LO + 1];
		scr_en = ctrl_ff[aof_pkg::CTRL_SCR_BIT];
		dith_en = ctrl_ff[aof_pkg::CTRL_DITH_BIT];
		demux = (om == aof_pkg::OM_DEMUX);
		lvds = ctrl_ff[aof_pkg::CTRL_OM_LO + 1];
		// the value now on the dither dac is the one to take back out
		corr = {conv_result[15], conv_result} -
			(dith_en ? {3'h0, dither_ff} : 17'sh00000);
		ovr = (corr > aof_pkg::CODE_MAX) || (corr < aof_pkg::CODE_MIN);
		clamped = corr[13:0];
		if (ovr) begin
			clamped = corr[16] ? aof_pkg::CLAMP_LO : aof_pkg::CLAMP_HI;
		end
		fmtd = twos ? clamped : clamped ^ aof_pkg::MSB_FLIP;
		// demux updates only when clock A is about to fall
		out_upd = enc_fall & (~demux | ~phase_ff);
		nxt_lfsr = lfsr_ff;
		nxt_dither = dither_ff;
		nxt_pend_data = pend_data_ff;
		nxt_pend_flag = pend_flag_ff;
		nxt_holdb_data = holdb_data_ff;
		nxt_holdb_flag = holdb_flag_ff;
		nxt_phase = demux ? phase_ff : 1'b0;
		nxt_clk_a = clk_a_ff;
		if (enc_rise) begin
			nxt_lfsr = {lfsr_ff[13:0], lfsr_ff[14] ^ lfsr_ff[13]};
			nxt_dither = dith_en ? nxt_lfsr[13:0] : 14'h0000;
			if (demux && phase_ff) begin
				nxt_holdb_data = fmtd;
				nxt_holdb_flag = ovr;
			end else begin
				nxt_pend_data = fmtd;
				nxt_pend_flag = ovr;
			end
			nxt_phase = demux & ~phase_ff;
			if (!demux) begin
				nxt_clk_a = 1'b1;
			end
		end
		if (enc_fall) begin
			nxt_clk_a = demux ? phase_ff : 1'b0;
		end
		nxt_bus_a = bus_a_ff;
		nxt_bus_b = bus_b_ff;
		nxt_flag_a = flag_a_ff;
		nxt_flag_b = flag_b_ff;
		nxt_ovr_p = ovr_p_ff;
		stat_set = 2'h0;
		if (out_upd) begin
			// lsb, flags and clocks bypass the scrambler
			nxt_bus_a = f_scr(pend_data_ff, scr_en);
			nxt_bus_b = demux ? f_scr(holdb_data_ff, scr_en) : 14'h0000;
			nxt_flag_a = ~lvds & pend_flag_ff;
			nxt_flag_b = demux & holdb_flag_ff;
			nxt_ovr_p = lvds & pend_flag_ff;
			stat_set[aof_pkg::STAT_SMP_BIT] = 1'b1;
			stat_set[aof_pkg::STAT_OVR_BIT] = pend_flag_ff | (demux & holdb_flag_ff);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lfsr_ff <= aof_pkg::LFSR_SEED;
			dither_ff <= 14'h0000;
			pend_data_ff <= 14'h0000;
			pend_flag_ff <= 1'b0;
			holdb_data_ff <= 14'h0000;
			holdb_flag_ff <= 1'b0;
			phase_ff <= 1'b0;
			bus_a_ff <= 14'h0000;
			bus_b_ff <= 14'h0000;
			flag_a_ff <= 1'b0;
			flag_b_ff <= 1'b0;
			ovr_p_ff <= 1'b0;
			ovr_n_ff <= 1'b1;
			clk_a_ff <= 1'b0;
			clk_b_ff <= 1'b1;
			dcs_ff <= 1'b0;
			lvds_en_ff <= 1'b0;
			lvds_lp_ff <= 1'b0;
		end else begin
			lfsr_ff <= nxt_lfsr;
			dither_ff <= nxt_dither;
			pend_data_ff <= nxt_pend_data;
			pend_flag_ff <= nxt_pend_flag;
			holdb_data_ff <= nxt_holdb_data;
			holdb_flag_ff <= nxt_holdb_flag;
			phase_ff <= nxt_phase;
			bus_a_ff <= nxt_bus_a;
			bus_b_ff <= nxt_bus_b;
			flag_a_ff <= nxt_flag_a;
			flag_b_ff <= nxt_flag_b;
			ovr_p_ff <= nxt_ovr_p;
			ovr_n_ff <= ~nxt_ovr_p;
			clk_a_ff <= nxt_clk_a;
			clk_b_ff <= ~nxt_clk_a;
			dcs_ff <= ctrl_ff[0] ^ ctrl_ff[1];
			lvds_en_ff <= lvds;
			lvds_lp_ff <= (om == aof_pkg::OM_LVDS_LP);
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign dither_dac = dither_ff;
	assign duty_stab_en = dcs_ff;
	assign lvds_enable = lvds_en_ff;
	assign lvds_low_power = lvds_lp_ff;
	assign bus_a_data = bus_a_ff;
	assign bus_b_data = bus_b_ff;
	assign bus_a_range_flag = flag_a_ff;
	assign bus_b_range_flag = flag_b_ff;
	assign over_range_flag_p = ovr_p_ff;
	assign over_range_flag_n = ovr_n_ff;
	assign forwarded_clock_a = clk_a_ff;
	assign forwarded_clock_b = clk_b_ff;
	assign irq = irq_ff;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_upd;
		out_upd;
	endsequence

	sequence s_demux_rise;
		enc_rise && demux;
	endsequence

	AST_FMT: assert property (enc_rise && !ovr && !(demux && phase_ff) |=>
		pend_data_ff == $past(twos ? corr[13:0] : {~corr[13], corr[12:0]}))
		else $error("sample format wrong");
	AST_DCS: assert property ($stable(ctrl_ff) |->
		duty_stab_en == (ctrl_ff[1:0] inside {2'h1, 2'h2}))
		else $error("stabilizer enable wrong");
	AST_OVR: assert property (enc_rise && !dith_en && !(demux && phase_ff) &&
		(conv_result > 16'sh1FFF || conv_result < 16'shE000) |=> pend_flag_ff)
		else $error("over-range not flagged");
	AST_FLAG_A: assert property (s_upd and !lvds |=>
		bus_a_range_flag == $past(pend_flag_ff) && !over_range_flag_p)
		else $error("bus A range flag wrong");
	AST_LVDS_FLAG: assert property (s_upd and lvds |=>
		over_range_flag_p == $past(pend_flag_ff) && over_range_flag_n != over_range_flag_p)
		else $error("differential range flag wrong");
	AST_CLK_COPY: assert property (enc_rise && !demux |=> forwarded_clock_a)
		else $error("forwarded clock not following encode");
	AST_A_EDGE: assert property ($changed(bus_a_data) |->
		$fell(forwarded_clock_a) && $rose(forwarded_clock_b))
		else $error("bus A changed off the clock A fall");
	AST_B_EDGE: assert property ($changed(bus_b_data) |-> $fell(forwarded_clock_a))
		else $error("bus B changed off the clock A fall");
	AST_FULL_B: assert property (s_upd and om == aof_pkg::OM_FULL |=> bus_b_data == 14'h0000)
		else $error("bus B driven in full rate");
	AST_HALF: assert property (enc_fall && demux |=> forwarded_clock_a == $past(phase_ff))
		else $error("demux clock not at half rate");
	AST_SCR: assert property (s_upd and scr_en |=>
		bus_a_data[13:1] == $past(pend_data_ff[13:1] ^ {13{pend_data_ff[0]}}))
		else $error("scrambled bits wrong");
	AST_LSB: assert property (s_upd |=> bus_a_data[0] == $past(pend_data_ff[0]))
		else $error("lsb altered");
	AST_PASS: assert property (s_upd and !scr_en |=> bus_a_data == $past(pend_data_ff))
		else $error("data altered with scrambler off");
	AST_DITH: assert property (enc_rise && dith_en && twos && !ovr &&
		!(demux && phase_ff) |=> pend_data_ff == $past(conv_result[13:0] - dither_dac))
		else $error("dither not subtracted");
	AST_MODE: assert property ($stable(ctrl_ff) |-> lvds_enable == ctrl_ff[3] &&
		lvds_low_power == (ctrl_ff[3:2] == 2'h2))
		else $error("output mode select wrong");
	AST_ROUTE: assert property (s_demux_rise ##1 demux |-> phase_ff != $past(phase_ff))
		else $error("demux phase not alternating");
	AST_ALIGN: assert property (s_upd and demux |=>
		bus_b_range_flag == $past(holdb_flag_ff))
		else $error("bus B flag misaligned");

endmodule

`default_nettype wire

// >>> dv/aof_rx_model.sv
// receiving logic model: latches the sample buses on the forwarded clock
`timescale 1ns/1ps
`default_nettype none

module aof_rx_model (
	// forwarded clock and buses
	input wire logic forwarded_clock_a,
	input wire logic [13:0] bus_a_data,
	input wire logic [13:0] bus_b_data,
	// receiver setting
	input wire logic descramble_en,
	// recovered samples
	output logic [13:0] rx_a,
	output logic [13:0] rx_b
);
	// latch on the rise, half a period away from any bus update
	always @(posedge forwarded_clock_a) begin
		rx_a <= descramble_en ? (bus_a_data ^ {{13{bus_a_data[0]}}, 1'b0}) : bus_a_data;
		rx_b <= descramble_en ? (bus_b_data ^ {{13{bus_b_data[0]}}, 1'b0}) : bus_b_data;
	end
endmodule

`default_nettype wire

// >>> dv/tb_top.sv
// testbench: formats, flags, clocks, demux pairs, irq and apb of the formatter
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	typedef struct packed {
		logic [5:0] ctrl;
		logic [15:0] res;
		logic [13:0] plain;
		logic [13:0] bus;
		logic flag;
	} aof_row_type;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic encode_clock_in, duty_stab_en, lvds_enable, lvds_low_power;
	logic signed [15:0] conv_result, res_set;
	logic [13:0] dither_dac, bus_a_data, bus_b_data, rx_a, rx_b, a_q, b_q;
	logic bus_a_range_flag, bus_b_range_flag, over_range_flag_p, over_range_flag_n;
	logic forwarded_clock_a, forwarded_clock_b, ramp_on, mon_on, enc_q, ca_q;
	logic [5:0] cur_ctrl;
	int err_total, compares;
	aof_row_type rows [9] = '{
		'{6'h03, 16'h0123, 14'h0123, 14'h0123, 1'b0},
		'{6'h00, 16'h0123, 14'h2123, 14'h2123, 1'b0},
		'{6'h01, 16'hFFFF, 14'h1FFF, 14'h1FFF, 1'b0},
		'{6'h03, 16'h2000, 14'h1FFF, 14'h1FFF, 1'b1},
		'{6'h02, 16'hDFFF, 14'h2000, 14'h2000, 1'b1},
		'{6'h13, 16'h0005, 14'h0005, 14'h3FFB, 1'b0},
		'{6'h10, 16'h0004, 14'h2004, 14'h2004, 1'b0},
		'{6'h0F, 16'h2000, 14'h1FFF, 14'h1FFF, 1'b1},
		'{6'h0A, 16'h0001, 14'h0001, 14'h0001, 1'b0}
	};

	aof_top i_aof_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .encode_clock_in(encode_clock_in), .conv_result(conv_result),
		.dither_dac(dither_dac), .duty_stab_en(duty_stab_en), .lvds_enable(lvds_enable),
		.lvds_low_power(lvds_low_power), .bus_a_data(bus_a_data), .bus_b_data(bus_b_data),
		.bus_a_range_flag(bus_a_range_flag), .bus_b_range_flag(bus_b_range_flag),
		.over_range_flag_p(over_range_flag_p), .over_range_flag_n(over_range_flag_n),
		.forwarded_clock_a(forwarded_clock_a), .forwarded_clock_b(forwarded_clock_b),
		.irq(irq));
	aof_rx_model i_aof_rx_model (.forwarded_clock_a(forwarded_clock_a),
		.bus_a_data(bus_a_data), .bus_b_data(bus_b_data), .descramble_en(cur_ctrl[4]),
		.rx_a(rx_a), .rx_b(rx_b));

	always #12.5 pclk = ~pclk;
	// encode runs at one eighth of pclk, its edges always on a pclk falling edge
	always #100 encode_clock_in = ~encode_clock_in;

	////////////////////////////////////////////////////////////////////////////////
	// ramp source steps after each encode fall, well clear of the sampling point
	// with the ramp off the source holds the value the scenario set
	always @(posedge pclk) begin
		enc_q <= encode_clock_in;
		if (!ramp_on) begin
			conv_result <= res_set;
		end else if (enc_q && !encode_clock_in) begin
			conv_result <= conv_result + 16'sh0001;
		end
	end

	// buses may only move on the edge where clock a falls
	always @(posedge pclk) begin
		if (mon_on && (bus_a_data !== a_q || bus_b_data !== b_q) && !(ca_q && !forwarded_clock_a)) begin
			err_total++;
			$display("CHECK FAILED bus_edge expected clock_a fall seen %b", forwarded_clock_a);
		end
		a_q <= bus_a_data;
		b_q <= bus_b_data;
		ca_q <= forwarded_clock_a;
	end

	////////////////////////////////////////////////////////////////////////////////
	task close_out;
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task chk14(input string nm, input logic [13:0] e, input logic [13:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task chk1(input string nm, input logic e, input logic g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %b seen %b", nm, e, g);
		end
	endtask

	task apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] rd,
		output logic e);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			err_total++;
			close_out();
		end
		@(posedge pclk);
	endtask

	task apb_wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic e;
		apb(a, 1'b1, d, rd, e);
		if (a == aof_pkg::REG_CTRL) begin
			cur_ctrl = d[5:0];
		end
	endtask

	task rises(input int cyc, input int want, output int n);
		logic p;
		p = forwarded_clock_a;
		n = 0;
		for (int c = 0; c < cyc && n < want; c++) begin
			@(posedge pclk);
			if (forwarded_clock_a && !p) begin
				n++;
			end
			p = forwarded_clock_a;
		end
	endtask

	task wait_rise(input int k);
		int n;
		rises(2000, k, n);
		if (n < k) begin
			err_total++;
			$display("CHECK FAILED clock_a_rise expected %0d seen %0d", k, n);
			close_out();
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		aof_row_type r;
		logic [31:0] d;
		logic e;
		int n;
		pclk = 0;
		presetn = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 8'h00;
		pwdata = 32'h0;
		encode_clock_in = 0;
		res_set = 16'sh0000;
		ramp_on = 0;
		mon_on = 0;
		cur_ctrl = 6'h00;
		err_total = 0;
		compares = 0;
		repeat (4) @(posedge pclk);
		chk1("pready_rst", 1'b0, pready);
		chk1("clock_b_rst", 1'b1, forwarded_clock_b);
		chk1("flag_n_rst", 1'b1, over_range_flag_n);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(aof_pkg::REG_CTRL, 1'b0, 32'h0, d, e);
		chk14("ctrl_rst", 14'h0000, d[13:0]);
		apb(aof_pkg::REG_MASK, 1'b0, 32'h0, d, e);
		chk14("mask_rst", 14'h0000, d[13:0]);
		apb(8'h10, 1'b0, 32'h0, d, e);
		chk1("unmapped_err", 1'b1, e);
		chk1("unmapped_zero", 1'b1, d == 32'h0);
		mon_on <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			r = rows[i];
			res_set <= r.res;
			apb_wr(aof_pkg::REG_CTRL, {26'h0, r.ctrl});
			wait_rise(3);
			chk14("bus_a", r.bus, bus_a_data);
			chk14("rx_a", r.plain, rx_a);
			chk14("bus_b", 14'h0000, bus_b_data);
			chk1("stab", r.ctrl[0] ^ r.ctrl[1], duty_stab_en);
			chk1("lvds", r.ctrl[3], lvds_enable);
			chk1("lvds_lp", r.ctrl[3:2] == 2'h2, lvds_low_power);
			chk1("flag_a", r.ctrl[3] ? 1'b0 : r.flag, bus_a_range_flag);
			chk1("flag_p", r.ctrl[3] & r.flag, over_range_flag_p);
			chk1("flag_n", ~(r.ctrl[3] & r.flag), over_range_flag_n);
		end
		apb_wr(aof_pkg::REG_CTRL, 32'h03);
		rises(160, 1000, n);
		chk1("full_rate", 1'b1, n >= 19 && n <= 21);
		// over-range then quiet: the sticky bit must survive until read
		apb(aof_pkg::REG_STAT, 1'b0, 32'h0, d, e);
		res_set <= 16'sh2000;
		wait_rise(3);
		res_set <= 16'sh0010;
		wait_rise(3);
		chk1("irq_masked", 1'b0, irq);
		apb_wr(aof_pkg::REG_MASK, 32'h1);
		repeat (3) @(posedge pclk);
		chk1("irq_set", 1'b1, irq);
		apb(aof_pkg::REG_STAT, 1'b0, 32'h0, d, e);
		chk1("stat_ovr", 1'b1, d[0]);
		chk1("stat_smp", 1'b1, d[1]);
		repeat (3) @(posedge pclk);
		chk1("irq_clr", 1'b0, irq);
		apb(aof_pkg::REG_STAT, 1'b0, 32'h0, d, e);
		chk1("stat_clr", 1'b0, d[0]);
		apb_wr(aof_pkg::REG_CTRL, 32'h23);
		wait_rise(2);
		chk1("dither_live", 1'b1, dither_dac !== 14'h0000);
		apb_wr(aof_pkg::REG_CTRL, 32'h03);
		wait_rise(2);
		chk14("dither_off", 14'h0000, dither_dac);
		res_set <= 16'sh0100;
		apb_wr(aof_pkg::REG_CTRL, 32'h07);
		ramp_on <= 1'b1;
		wait_rise(3);
		rises(160, 1000, n);
		chk1("half_rate", 1'b1, n >= 9 && n <= 11);
		for (int k = 0; k < 4; k++) begin
			wait_rise(1);
			chk14("pair", rx_a + 14'h0001, rx_b);
			chk1("pair_flag_b", 1'b0, bus_b_range_flag);
		end
		// both halves of a pair out of range: each bus raises its own flag
		ramp_on <= 1'b0;
		res_set <= 16'sh2000;
		wait_rise(3);
		chk14("demux_a_clamp", 14'h1FFF, bus_a_data);
		chk14("demux_b_clamp", 14'h1FFF, bus_b_data);
		chk1("demux_flag_a", 1'b1, bus_a_range_flag);
		chk1("demux_flag_b", 1'b1, bus_b_range_flag);
		close_out();
	end
endmodule

`default_nettype wire
